// ### rtl/ccag_consts.vh
`ifndef CCAG_CONSTS_VH
`define CCAG_CONSTS_VH
// Register byte offsets
`define CCAG_OFF_PMS        12'h000
`define CCAG_OFF_PTR        12'h004
`define CCAG_OFF_PAGE       12'h008
`define CCAG_OFF_BSTART     12'h00c
`define CCAG_OFF_BSIZE      12'h010
`define CCAG_OFF_AUX0       12'h014
`define CCAG_OFF_TMP0       12'h018
`define CCAG_OFF_CTRL       12'h01c
`define CCAG_OFF_CMD        12'h020
`define CCAG_OFF_ADDR       12'h024
`define CCAG_OFF_BUS        12'h028
`define CCAG_OFF_GSTART     12'h040
`define CCAG_OFF_GSIZE      12'h050
`define CCAG_OFF_GSTEP      12'h004
// Field positions
`define CCAG_PMS_CP_BIT     8
`define CCAG_CTRL_LEGACY    0
`define CCAG_CTRL_CIRCQ     1
// Reset values
`define CCAG_PMS_RST        16'h0000
// Pointer modes
`define CCAG_MODE_PLAIN     3'h0
`define CCAG_MODE_INC       3'h1
`define CCAG_MODE_DEC       3'h2
`define CCAG_MODE_ADD_AUX0  3'h3
`define CCAG_MODE_ADD_TMP0  3'h4
// Access kinds
`define CCAG_KIND_OPER      2'h0
`define CCAG_KIND_RD16      2'h1
`define CCAG_KIND_WR16      2'h2
`define CCAG_KIND_MV32      2'h3
`endif

// ### rtl/ccag_step.v
`timescale 1ns/1ps
// Pointer step with linear or circular wrap
module ccag_step
(
  // Operands
  input  wire [15:0] ptr,
  input  wire [15:0] delta,
  input  wire [15:0] bsize,
  input  wire        circ,
  // Result
  output reg  [15:0] ptr_nxt
);
  reg [16:0] sum;
  reg [16:0] ext;
  // Linear wraps mod 64K, circular wraps in 0..size-1
  always @*
  begin
    sum = {1'b0, ptr} + {1'b0, delta};
    ext = {1'b0, ptr} + {delta[15], delta};
    if (!circ || bsize == 16'h0000)
      ptr_nxt = sum[15:0];
    else if (delta[15] && ext[16] == 1'b1 && ptr < (~delta + 16'h0001))
      ptr_nxt = ptr + delta + bsize;
    else if (!delta[15] && (sum >= {1'b0, bsize}))
      ptr_nxt = sum[15:0] - bsize;
    else
      ptr_nxt = sum[15:0];
  end
endmodule

// ### rtl/ccag_top.v
`timescale 1ns/1ps
`include "ccag_consts.vh"
module ccag_top
#(
  parameter INT_LIMIT = 23'h010000
)
(
  // AHB-Lite slave
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // Address request from core
  input  wire        req_valid,
  input  wire [2:0]  req_mode,
  input  wire        req_wide,
  input  wire [1:0]  req_kind,
  input  wire        req_circq,
  input  wire        req_dual,
  // Generated address
  output reg         addr_valid_r,
  output reg  [22:0] addr_r,
  output reg         addr_err_r,
  output reg         coef_read_bus_r,
  output reg         primary_read_bus_r,
  output reg         secondary_read_bus_r,
  output reg         primary_write_bus_r,
  output reg         secondary_write_bus_r,
  output reg         dual_share_r,
  // Circular configuration for aux pointers
  output wire [7:0]  aux_ptr_circular_bit,
  output wire [15:0] buffer_start_ptr01,
  output wire [15:0] buffer_start_ptr23,
  output wire [15:0] buffer_start_ptr45,
  output wire [15:0] buffer_start_ptr67,
  output wire [15:0] buffer_size_ptr0to3,
  output wire [15:0] buffer_size_ptr4to7
);

////////////////////////////////////////////////////////////////////////
  // Registers
  reg [15:0] pointer_mode_status_r;
  reg [15:0] coefficient_pointer_r;
  reg [6:0]  coefficient_page_high_r;
  reg [15:0] coefficient_buffer_start_r;
  reg [15:0] coefficient_buffer_size_r;
  reg [15:0] aux_pointer_zero_r;
  reg [15:0] temp_register_zero_r;
  reg [1:0]  ctrl_r;
  reg [15:0] grp_start_r [0:3];
  reg [15:0] grp_size_r  [0:1];
  // AHB data-phase state
  reg        wr_pend_r;
  reg        rd_pend_r;
  reg [11:0] dph_addr_r;
  reg [31:0] hrdata_r;
  // Bus-issued command
  reg        cmd_pulse_r;
  reg [8:0]  cmd_r;

  // Mode bits from control and status
  wire legacy_compat_mode = ctrl_r[`CCAG_CTRL_LEGACY];
  wire coef_ptr_circular_bit = pointer_mode_status_r[`CCAG_PMS_CP_BIT];
  // Bus commands may be forced circular, like the qualifier
  wire circq_force = ctrl_r[`CCAG_CTRL_CIRCQ];

  // Aux pointer units read their mode bits and group registers here
  assign aux_ptr_circular_bit = pointer_mode_status_r[7:0];
  assign buffer_start_ptr01   = grp_start_r[0];
  assign buffer_start_ptr23   = grp_start_r[1];
  assign buffer_start_ptr45   = grp_start_r[2];
  assign buffer_start_ptr67   = grp_start_r[3];
  assign buffer_size_ptr0to3  = grp_size_r[0];
  assign buffer_size_ptr4to7  = grp_size_r[1];

////////////////////////////////////////////////////////////////////////
  // Request selection: core port or bus command
  // Core port wins when both ask in one cycle
  wire       go    = req_valid | cmd_pulse_r;
  wire [2:0] mode  = req_valid ? req_mode  : cmd_r[2:0];
  wire       wide  = req_valid ? req_wide  : cmd_r[3];
  wire [1:0] kind  = req_valid ? req_kind  : cmd_r[5:4];
  wire       circq = req_valid ? req_circq : (cmd_r[6] | circq_force);
  wire       dual  = req_valid ? req_dual  : cmd_r[7];

  // Circular decision
  wire circ = circq | coef_ptr_circular_bit;

  // Post-modification amount
  reg [15:0] delta;
  reg        mode_ok;
  always @*
  begin
    delta   = 16'h0000;
    mode_ok = 1'b1;
    case (mode)
      `CCAG_MODE_PLAIN:    delta = 16'h0000;
      `CCAG_MODE_INC:      delta = wide ? 16'h0002 : 16'h0001;
      `CCAG_MODE_DEC:      delta = wide ? 16'hfffe : 16'hffff;
      `CCAG_MODE_ADD_AUX0:
      begin
        delta   = aux_pointer_zero_r;
        mode_ok = legacy_compat_mode;
      end
      `CCAG_MODE_ADD_TMP0:
      begin
        delta   = temp_register_zero_r;
        mode_ok = ~legacy_compat_mode;
      end
      default: mode_ok = 1'b0;
    endcase
  end

  // Next pointer from the step unit; page is never an input
  wire [15:0] ptr_step;
  ccag_step i_ccag_step
  (
    .ptr     (coefficient_pointer_r),
    .delta   (delta),
    .bsize   (coefficient_buffer_size_r),
    .circ    (circ),
    .ptr_nxt (ptr_step)
  );

  // Address formed before the pointer changes
  wire [15:0] low_addr = circ ?
    coefficient_pointer_r + coefficient_buffer_start_r :
    coefficient_pointer_r;
  // Page register supplies the upper seven bits
  wire [22:0] full_addr = {coefficient_page_high_r, low_addr};
  // Coefficient bus has no path to external memory
  wire        is_ext = full_addr >= INT_LIMIT;

////////////////////////////////////////////////////////////////////////
  // Address and bus steering outputs
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_valid_r          <= 1'b0;
      addr_r                <= 23'h000000;
      addr_err_r            <= 1'b0;
      coef_read_bus_r       <= 1'b0;
      primary_read_bus_r    <= 1'b0;
      secondary_read_bus_r  <= 1'b0;
      primary_write_bus_r   <= 1'b0;
      secondary_write_bus_r <= 1'b0;
      dual_share_r          <= 1'b0;
    end
    else
    begin
      // Pulses drop each cycle unless a request lands
      addr_valid_r          <= go & mode_ok;
      addr_err_r            <= go & (~mode_ok |
                               (kind == `CCAG_KIND_OPER & is_ext));
      coef_read_bus_r       <= 1'b0;
      primary_read_bus_r    <= 1'b0;
      secondary_read_bus_r  <= 1'b0;
      primary_write_bus_r   <= 1'b0;
      secondary_write_bus_r <= 1'b0;
      dual_share_r          <= 1'b0;
      if (go & mode_ok)
      begin
        addr_r <= full_addr;
        case (kind)
          `CCAG_KIND_OPER:
          begin
            coef_read_bus_r <= ~is_ext;
            dual_share_r    <= dual;
          end
          `CCAG_KIND_RD16: primary_read_bus_r  <= 1'b1;
          `CCAG_KIND_WR16: primary_write_bus_r <= 1'b1;
          `CCAG_KIND_MV32:
          begin
            secondary_read_bus_r  <= 1'b1;
            primary_read_bus_r    <= 1'b1;
            secondary_write_bus_r <= 1'b1;
            primary_write_bus_r   <= 1'b1;
          end
          default: coef_read_bus_r <= 1'b0;
        endcase
      end
    end
  end

////////////////////////////////////////////////////////////////////////
  // AHB-Lite address phase capture
  wire       ahb_go   = hsel & hready & htrans[1];
  wire       bus_wr   = wr_pend_r;
  wire [11:0] woff    = dph_addr_r;
  // Command register write launches a request next cycle
  wire        cmd_wr  = bus_wr && woff == `CCAG_OFF_CMD;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r  <= 1'b0;
      rd_pend_r  <= 1'b0;
      dph_addr_r <= 12'h000;
    end
    else
    begin
      wr_pend_r <= ahb_go & hwrite;
      rd_pend_r <= ahb_go & ~hwrite;
      if (ahb_go)
        dph_addr_r <= haddr[11:0];
    end
  end

  // Zero-wait slave, response always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // Read mux, registered in address phase
  reg [31:0] rd_mux;
  always @*
  begin
    case (haddr[11:0])
      `CCAG_OFF_PMS:    rd_mux = {16'h0000, pointer_mode_status_r};
      `CCAG_OFF_PTR:    rd_mux = {16'h0000, coefficient_pointer_r};
      `CCAG_OFF_PAGE:   rd_mux = {25'h0000000, coefficient_page_high_r};
      `CCAG_OFF_BSTART: rd_mux = {16'h0000, coefficient_buffer_start_r};
      `CCAG_OFF_BSIZE:  rd_mux = {16'h0000, coefficient_buffer_size_r};
      `CCAG_OFF_AUX0:   rd_mux = {16'h0000, aux_pointer_zero_r};
      `CCAG_OFF_TMP0:   rd_mux = {16'h0000, temp_register_zero_r};
      `CCAG_OFF_CTRL:   rd_mux = {30'h00000000, ctrl_r};
      `CCAG_OFF_ADDR:   rd_mux = {9'h000, addr_r};
      `CCAG_OFF_BUS:    rd_mux = {25'h0000000, addr_err_r, dual_share_r,
                                  secondary_write_bus_r, primary_write_bus_r,
                                  secondary_read_bus_r, primary_read_bus_r,
                                  coef_read_bus_r};
      default:          rd_mux = 32'h00000000;
    endcase
  end

  // Read data launched at the address phase edge
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= 32'h00000000;
    else if (ahb_go & ~hwrite)
      hrdata_r <= rd_mux;
  end

////////////////////////////////////////////////////////////////////////
  // Register writes and pointer update
  // Shared start registers, one per pointer pair
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_start
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          grp_start_r[g] <= 16'h0000;
        else if (bus_wr && woff == `CCAG_OFF_GSTART + `CCAG_OFF_GSTEP * g)
          grp_start_r[g] <= hwdata[15:0];
      end
    end
    // Shared size registers, one per group of four
    for (g = 0; g < 2; g = g + 1)
    begin : g_size
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          grp_size_r[g] <= 16'h0000;
        else if (bus_wr && woff == `CCAG_OFF_GSIZE + `CCAG_OFF_GSTEP * g)
          grp_size_r[g] <= hwdata[15:0];
      end
    end
  endgenerate

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pointer_mode_status_r      <= `CCAG_PMS_RST;
      coefficient_pointer_r      <= 16'h0000;
      coefficient_page_high_r    <= 7'h00;
      coefficient_buffer_start_r <= 16'h0000;
      coefficient_buffer_size_r  <= 16'h0000;
      aux_pointer_zero_r         <= 16'h0000;
      temp_register_zero_r       <= 16'h0000;
      ctrl_r                     <= 2'h0;
      cmd_pulse_r                <= 1'b0;
      cmd_r                      <= 9'h000;
    end
    else
    begin
      cmd_pulse_r <= cmd_wr;
      if (cmd_wr)
        cmd_r <= hwdata[8:0];
      // Post-modify after address; page never touched
      if (go & mode_ok)
        coefficient_pointer_r <= ptr_step;
      // Bus write comes last, so it wins over a same-cycle step
      if (bus_wr)
      begin
        case (woff)
          `CCAG_OFF_PMS:    pointer_mode_status_r <=
                              {7'h00, hwdata[8:0]};
          `CCAG_OFF_PTR:    coefficient_pointer_r <= hwdata[15:0];
          `CCAG_OFF_PAGE:   coefficient_page_high_r <= hwdata[6:0];
          `CCAG_OFF_BSTART: coefficient_buffer_start_r <= hwdata[15:0];
          `CCAG_OFF_BSIZE:  coefficient_buffer_size_r <= hwdata[15:0];
          `CCAG_OFF_AUX0:   aux_pointer_zero_r <= hwdata[15:0];
          `CCAG_OFF_TMP0:   temp_register_zero_r <= hwdata[15:0];
          `CCAG_OFF_CTRL:   ctrl_r <= hwdata[1:0];
          default:          ctrl_r <= ctrl_r;
        endcase
      end
    end
  end
endmodule

// ### test/ccag_top_asserts.sv
`timescale 1ns/1ps
// Port checks of the address generator
module ccag_chk
#(
  parameter INT_LIMIT = 23'h010000
)
(
  // Clock, reset and request
  input wire        hclk,
  input wire        hresetn,
  input wire        req_valid,
  input wire [2:0]  req_mode,
  input wire [1:0]  req_kind,
  input wire        req_dual,
  // Results
  input wire        addr_valid_r,
  input wire [22:0] addr_r,
  input wire        addr_err_r,
  input wire        coef_read_bus_r,
  input wire        primary_read_bus_r,
  input wire        secondary_read_bus_r,
  input wire        primary_write_bus_r,
  input wire        secondary_write_bus_r,
  input wire        dual_share_r
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  answer_next_a: assert property (
    req_valid |=> addr_valid_r || addr_err_r) else $error("no answer");
  oper_bus_a: assert property (
    req_valid && req_kind == 2'h0 ##1 !addr_err_r |->
    coef_read_bus_r && !primary_read_bus_r) else $error("coef bus");
  internal_a: assert property (
    coef_read_bus_r |-> addr_r < INT_LIMIT) else $error("external");
  rd16_bus_a: assert property (
    req_valid && req_kind == 2'h1 |=> addr_err_r ||
    primary_read_bus_r && !coef_read_bus_r) else $error("rd16 bus");
  wr16_bus_a: assert property (
    req_valid && req_kind == 2'h2 |=> addr_err_r ||
    primary_write_bus_r && !coef_read_bus_r) else $error("wr16 bus");
  mv32_bus_a: assert property (
    req_valid && req_kind == 2'h3 |=> addr_err_r || !coef_read_bus_r &&
    (secondary_read_bus_r || secondary_write_bus_r)) else $error("mv32");
  dual_share_a: assert property (
    req_valid && req_dual && req_kind == 2'h0 |=> addr_err_r ||
    dual_share_r) else $error("dual share");
  bad_mode_a: assert property (
    req_valid && req_mode > 3'h4 |=> addr_err_r) else $error("bad mode");
  // Main scenarios reached
  cover property (req_valid && req_kind == 2'h0 ##1 coef_read_bus_r);
  cover property (req_valid && req_dual ##1 dual_share_r);
  cover property (addr_err_r);
endmodule

// ### test/ccag_mem_model.sv
`timescale 1ns/1ps
// Memory banks seen through the operand buses
module ccag_mem_model
#(
  parameter INT_LIMIT = 23'h010000,
  // Bank holding the dual-pointer operands in this model
  parameter DUAL_BANK = 7'h02
)
(
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // Strobes from the generator
  input  wire        addr_valid_r,
  input  wire [22:0] addr_r,
  input  wire [5:0]  bus_in,
  // Last access seen
  output reg  [5:0]  bus_seen,
  output reg         ext_hit,
  output reg         bank_clash
);
  // Latch each access; coefficient bus has no external bank
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      bus_seen <= 6'h00;
      ext_hit  <= 1'b0;
      bank_clash <= 1'b0;
    end
    else if (addr_valid_r)
    begin
      bus_seen <= bus_in;
      ext_hit  <= bus_in[0] && addr_r >= INT_LIMIT;
      bank_clash <= bus_in[0] && addr_r[22:16] == DUAL_BANK;
    end
endmodule

// ### test/ccag_top_bench.sv
`timescale 1ns/1ps
`include "ccag_consts.vh"
// Self-checking bench for the address generator
module ccag_top_bench;
  // Drive and observe
  logic        hclk, hresetn, hsel, hwrite, req_valid, req_wide, err_s;
  logic        req_circq, req_dual, vld_s;
  logic [31:0] haddr, hwdata, rd, e;
  logic [1:0]  htrans, req_kind;
  logic [2:0]  hsize, req_mode;
  logic [5:0]  bmask [4] = '{6'h3f, 6'h3f, 6'h3f, 6'h3f};
  logic [5:0]  bexp [4] = '{6'h21, 6'h02, 6'h08, 6'h1e};
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, addr_valid_r, addr_err_r, ext_hit;
  wire         coef_read_bus_r, primary_read_bus_r, secondary_read_bus_r;
  wire         primary_write_bus_r, secondary_write_bus_r, dual_share_r;
  wire  [22:0] addr_r;
  wire  [7:0]  aux_ptr_circular_bit;
  wire  [15:0] buffer_start_ptr01, buffer_start_ptr23, buffer_start_ptr45;
  wire  [15:0] buffer_start_ptr67, buffer_size_ptr0to3, buffer_size_ptr4to7;
  wire  [5:0]  bus_seen;
  wire         bank_clash;
  int          failures, n_checks;
  // Design and memory model
  ccag_top i_ccag_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .req_valid, .req_mode, .req_wide, .req_kind, .req_circq, .req_dual,
    .addr_valid_r, .addr_r, .addr_err_r, .coef_read_bus_r,
    .primary_read_bus_r, .secondary_read_bus_r, .primary_write_bus_r,
    .secondary_write_bus_r, .dual_share_r, .aux_ptr_circular_bit,
    .buffer_start_ptr01, .buffer_start_ptr23, .buffer_start_ptr45,
    .buffer_start_ptr67, .buffer_size_ptr0to3, .buffer_size_ptr4to7);
  ccag_mem_model i_ccag_mem_model (.hclk, .hresetn, .addr_valid_r, .addr_r,
    .bus_in({dual_share_r, secondary_write_bus_r, primary_write_bus_r,
    secondary_read_bus_r, primary_read_bus_r, coef_read_bus_r}),
    .bus_seen, .ext_hit, .bank_clash);
  // Clock
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Compare and count
  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    n_checks++;
    if (s !== x)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask
  // Edge with hready high, bounded
  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      k++;
      if (k > 50)
      begin
        failures++;
        summarize();
      end
      @(posedge hclk);
    end
  endtask
  // One single word bus transfer
  task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    #1;
  endtask
  // One core request
  task automatic req(logic [2:0] m, logic w, logic [1:0] k, logic c);
    @(posedge hclk);
    req_valid <= 1'b1;
    req_mode  <= m;
    req_wide  <= w;
    req_kind  <= k;
    req_circq <= c;
    @(posedge hclk);
    req_valid <= 1'b0;
    #1;
    err_s = addr_err_r;
    vld_s = addr_valid_r;
    @(posedge hclk);
    #1;
  endtask
  // Test sequence
  initial
  begin
    {hresetn, hsel, hwrite, req_valid, req_wide, req_circq, req_dual} = '0;
    {haddr, hwdata, htrans, req_kind, hsize, req_mode} = '0;
    failures = 0;
    n_checks = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(0, `CCAG_OFF_PMS, 0);
    chk("status", rd, 0);
    chk("okay", hresp, 0);
    xfer(1, `CCAG_OFF_PMS, 32'h1a5);
    chk("aux bits", aux_ptr_circular_bit, 8'ha5);
    xfer(0, `CCAG_OFF_PMS, 0);
    chk("status", rd, 32'h1a5);
    for (int i = 0; i < 6; i++)
      xfer(1, 12'h040 + 12'(4 * i), 32'h1000 + i);
    for (int i = 0; i < 6; i++)
      chk("group", {buffer_start_ptr01, buffer_start_ptr23,
        buffer_start_ptr45, buffer_start_ptr67, buffer_size_ptr0to3,
        buffer_size_ptr4to7} >> (80 - 16 * i) & 16'hffff, 32'h1000 + i);
    $display("registers done");
    xfer(1, `CCAG_OFF_PMS, 0);
    xfer(1, `CCAG_OFF_PAGE, 32'h12);
    xfer(1, `CCAG_OFF_PTR, 32'hffff);
    req(`CCAG_MODE_INC, 0, `CCAG_KIND_RD16, 0);
    chk("addr", addr_r, 32'h12ffff);
    req(`CCAG_MODE_DEC, 1, `CCAG_KIND_RD16, 0);
    chk("addr", addr_r, 32'h120000);
    req(`CCAG_MODE_PLAIN, 0, `CCAG_KIND_RD16, 0);
    chk("addr", addr_r, 32'h12fffe);
    $display("linear done");
    xfer(1, `CCAG_OFF_AUX0, 32'hfffd);
    xfer(1, `CCAG_OFF_TMP0, 32'h5);
    for (int l = 0; l < 2; l++)
    begin
      xfer(1, `CCAG_OFF_CTRL, l);
      xfer(1, `CCAG_OFF_PTR, 32'h10);
      req(l ? `CCAG_MODE_ADD_TMP0 : `CCAG_MODE_ADD_AUX0, 0, 1, 0);
      chk("refused", err_s, 1);
      chk("no valid", vld_s, 0);
      req(3'h5, 0, 1, 0);
      chk("refused", err_s, 1);
      req(l ? `CCAG_MODE_ADD_AUX0 : `CCAG_MODE_ADD_TMP0, 0, 1, 0);
      req(`CCAG_MODE_PLAIN, 0, 1, 0);
      chk("indexed", addr_r, l ? 32'h12000d : 32'h120015);
    end
    $display("indexed done");
    xfer(1, `CCAG_OFF_CTRL, 0);
    xfer(1, `CCAG_OFF_BSTART, 32'h100);
    xfer(1, `CCAG_OFF_BSIZE, 32'h3);
    for (int c = 0; c < 3; c++)
    begin
      xfer(1, `CCAG_OFF_PMS, c == 0 ? 32'h100 : 32'h0);
      xfer(1, `CCAG_OFF_PTR, 32'h1);
      for (int j = 0; j < 4; j++)
      begin
        req(`CCAG_MODE_INC, 0, 1, c == 1);
        e = c == 2 ? 32'h120001 + j : 32'h120100 + (j + 1) % 3;
        chk("circular", addr_r, e);
      end
    end
    $display("circular done");
    xfer(1, `CCAG_OFF_PAGE, 0);
    xfer(1, `CCAG_OFF_PTR, 32'h10);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge hclk);
      req_dual <= (k == 0);
      req(`CCAG_MODE_INC, k == 3, 2'(k), 0);
      chk("operand addr", addr_r, 32'h10 + k);
      chk("buses", bus_seen & bmask[k], bexp[k]);
      chk("bank", bank_clash, 0);
    end
    $display("buses done");
    xfer(1, `CCAG_OFF_PAGE, 32'h1);
    req(`CCAG_MODE_PLAIN, 0, `CCAG_KIND_OPER, 0);
    chk("external", err_s, 1);
    chk("coef external", ext_hit, 0);
    $display("external done");
    xfer(1, `CCAG_OFF_PAGE, 0);
    xfer(1, `CCAG_OFF_PTR, 32'h1);
    xfer(1, `CCAG_OFF_CTRL, 32'h2);
    xfer(1, `CCAG_OFF_CMD, 32'h11);
    xfer(0, `CCAG_OFF_BUS, 0);
    chk("cmd buses", rd, 32'h2);
    xfer(0, `CCAG_OFF_ADDR, 0);
    chk("cmd addr", rd, 32'h101);
    xfer(0, `CCAG_OFF_PTR, 0);
    chk("cmd ptr", rd, 32'h2);
    $display("command done");
    summarize();
  end
endmodule
// Checker on the top module ports
bind ccag_top ccag_chk #(.INT_LIMIT(INT_LIMIT)) i_ccag_chk (.hclk, .hresetn,
  .req_valid, .req_mode, .req_kind, .req_dual, .addr_valid_r, .addr_r,
  .addr_err_r, .coef_read_bus_r, .primary_read_bus_r, .secondary_read_bus_r,
  .primary_write_bus_r, .secondary_write_bus_r, .dual_share_r);
